// [common/adc_seq_defs.vh]
// Register map, field positions and timing constants of the ADC sequencer
`ifndef ADC_SEQ_DEFS_VH
`define ADC_SEQ_DEFS_VH

// ------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------------
`define IDX_CLOCK_OPTION_CONFIG        8'h94
`define IDX_INTERRUPT_FLAGS            8'h95
`define IDX_SHARED_RESULT_LOW          8'haa
`define IDX_CONVERSION_RESULT_HIGH     8'hab
`define IDX_CHANNEL_SELECT             8'hb6
`define IDX_REFERENCE_PRESCALE_CONTROL 8'hef
`define IDX_START_CLEAR_CONTROL        8'hf8
`define IDX_CONVERTER_DATA             8'hc0

// ------------------------------------------------------------------
// Field positions
// ------------------------------------------------------------------
`define DIV_SEL_LSB       2
`define START_BIT         4
`define DONE_BIT          4
`define REF_SEL_LSB       0
`define BANDGAP_EN_BIT    2

// ------------------------------------------------------------------
// Reset values
// ------------------------------------------------------------------
`define RST_OPTION        8'h00
`define RST_FLAGS         8'h00
`define RST_CHANNEL       4'hf
`define RST_AUXILIARY_CONTROL_REGISTER          6'h00
`define RST_START_CLEAR_CONTROL          8'h00

// ------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------
`define CONV_CYCLES       6'd50
`define DIV_32            6'd32
`define DIV_16            6'd16
`define DIV_8             6'd8
`define DIV_4             6'd4

`endif

// [hw/conv_clock_div.v]
// Converter clock divider giving a one-cycle tick per converter clock
`timescale 1ns/1ns
`include "adc_seq_defs.vh"

module conv_clock_div (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       run,
  input  wire [1:0] div_sel,
  output reg        tick
);

  reg  [5:0] count;
  wire [5:0] limit;

  function [5:0] div_ratio;
    input [1:0] sel;
    begin
      case (sel)
        2'b00:   div_ratio = `DIV_32;
        2'b01:   div_ratio = `DIV_16;
        2'b10:   div_ratio = `DIV_8;
        default: div_ratio = `DIV_4;
      endcase
    end
  endfunction

  assign limit = div_ratio(div_sel);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= 6'h00;
      tick  <= 1'b0;
    end else if (!run) begin
      count <= 6'h00;
      tick  <= 1'b0;
    end else if (count == limit - 6'd1) begin
      count <= 6'h00;
      tick  <= 1'b1;
    end else begin
      count <= count + 6'd1;
      tick  <= 1'b0;
    end
  end

endmodule

// [hw/sar_adc_sequencer.v]
// APB-controlled sequencer for a 12-bit successive-approximation ADC
`timescale 1ns/1ns
`include "adc_seq_defs.vh"

module sar_adc_sequencer (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [11:0] conv_data,
  output reg         conv_clk_tick,
  output reg         conv_busy,
  output reg         conv_sample,
  output reg  [3:0]  channel_sel,
  output reg         chan_bandgap,
  output reg         chan_quarter_supply,
  output reg  [1:0]  reference_level_select,
  output reg         bandgap_enable,
  output reg         conv_done_irq
);

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  reg  [7:0]  clock_option_config;
  reg  [7:0]  interrupt_flags;
  reg  [3:0]  input_channel_select;
  reg  [5:0]  reference_prescale_control;
  reg  [7:0]  start_clear_control;
  reg  [11:0] result;
  reg  [5:0]  conv_count;
  reg  [11:0] data_meta;
  reg  [11:0] data_sync;

  wire        tick;
  wire        access;
  wire        wr;
  wire [7:0]  idx;
  wire        mapped;
  wire        conv_end;
  wire        start_wr_one;
  wire        start_wr_zero;

  // ------------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------------
  function is_mapped;
    input [7:0] i;
    begin
      case (i)
        `IDX_CLOCK_OPTION_CONFIG,
        `IDX_INTERRUPT_FLAGS,
        `IDX_SHARED_RESULT_LOW,
        `IDX_CONVERSION_RESULT_HIGH,
        `IDX_CHANNEL_SELECT,
        `IDX_REFERENCE_PRESCALE_CONTROL,
        `IDX_START_CLEAR_CONTROL,
        `IDX_CONVERTER_DATA: is_mapped = 1'b1;
        default:             is_mapped = 1'b0;
      endcase
    end
  endfunction

  // Zero-wait slave: answers in the first access cycle
  assign access = psel & penable;
  assign idx    = paddr[9:2];
  assign mapped = is_mapped(idx) & (paddr[1:0] == 2'b00) &
                  (paddr[11:10] == 2'b00);
  assign wr     = access & pwrite & mapped;
  // Reads need no access strobe: read data is set up in the setup cycle
  // and only stands for the one access cycle that follows

  assign start_wr_one  = wr & (idx == `IDX_START_CLEAR_CONTROL) &
                         pwdata[`START_BIT];
  assign start_wr_zero = wr & (idx == `IDX_START_CLEAR_CONTROL) &
                         ~pwdata[`START_BIT];

  // Conversion ends on the 50th converter clock of the run
  assign conv_end = tick & (conv_count == `CONV_CYCLES - 6'd1);

  // ------------------------------------------------------------------
  // Converter clock
  // ------------------------------------------------------------------
  conv_clock_div u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (start_clear_control[`START_BIT]),
    .div_sel (clock_option_config[`DIV_SEL_LSB +: 2]),
    .tick    (tick)
  );

  // Converter data comes from the analog core, so it is synchronised
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_meta <= 12'h000;
      data_sync <= 12'h000;
    end else begin
      data_meta <= conv_data;
      data_sync <= data_meta;
    end
  end

  // ------------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_option_config        <= `RST_OPTION;
      input_channel_select       <= `RST_CHANNEL;
      reference_prescale_control <= `RST_AUXILIARY_CONTROL_REGISTER;
    end else if (wr) begin
      case (idx)
        `IDX_CLOCK_OPTION_CONFIG:
          clock_option_config <= pwdata[7:0] & 8'hbc;
        `IDX_CHANNEL_SELECT:
          input_channel_select <= pwdata[3:0];
        `IDX_REFERENCE_PRESCALE_CONTROL:
          reference_prescale_control <= pwdata[5:0];
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------------
  // Start bit, done flag, result and cycle counter
  // ------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_clear_control <= `RST_START_CLEAR_CONTROL;
      interrupt_flags     <= `RST_FLAGS;
      result              <= 12'h000;
      conv_count          <= 6'h00;
    end else begin
      // Other bits of the start register are plain storage; the flag register stores only bits 2:0 and 5
      if (wr && idx == `IDX_START_CLEAR_CONTROL)
        start_clear_control <= pwdata[7:0];
      else if (conv_end)
        start_clear_control[`START_BIT] <= 1'b0;

      // Done flag: hardware set wins over any clear in the same cycle
      if (conv_end)
        interrupt_flags[`DONE_BIT] <= 1'b1;
      else if (start_wr_one)
        interrupt_flags[`DONE_BIT] <= 1'b0;
      else if (wr && idx == `IDX_INTERRUPT_FLAGS &&
               !pwdata[`DONE_BIT])
        interrupt_flags[`DONE_BIT] <= 1'b0;
      if (wr && idx == `IDX_INTERRUPT_FLAGS) begin
        interrupt_flags[3:0] <= pwdata[3:0] & 4'h7;
        interrupt_flags[5]   <= pwdata[5];
      end

      if (conv_end)
        result <= data_sync;

      // A fresh start restarts the count
      if (start_wr_one || start_wr_zero || conv_end)
        conv_count <= 6'h00;
      else if (start_clear_control[`START_BIT] && tick)
        conv_count <= conv_count + 6'd1;
    end
  end

  // ------------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !penable) begin
        pready  <= 1'b1;
        pslverr <= ~mapped;
        if (!pwrite) begin
          case (idx)
            `IDX_CLOCK_OPTION_CONFIG:
              prdata <= {24'h0, clock_option_config};
            `IDX_INTERRUPT_FLAGS:
              prdata <= {24'h0, interrupt_flags};
            `IDX_SHARED_RESULT_LOW:
              prdata <= {24'h0, result[3:0], 4'h0};
            `IDX_CONVERSION_RESULT_HIGH:
              prdata <= {24'h0, result[11:4]};
            `IDX_CHANNEL_SELECT:
              prdata <= {28'h0, input_channel_select};
            `IDX_REFERENCE_PRESCALE_CONTROL:
              prdata <= {26'h0, reference_prescale_control};
            `IDX_START_CLEAR_CONTROL:
              prdata <= {24'h0, start_clear_control};
            `IDX_CONVERTER_DATA:
              prdata <= {26'h0, conv_count};
            default:
              prdata <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // Outputs toward the converter core and the done interrupt
  // ------------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_clk_tick          <= 1'b0;
      conv_busy              <= 1'b0;
      conv_sample            <= 1'b0;
      channel_sel            <= `RST_CHANNEL;
      chan_bandgap           <= 1'b0;
      chan_quarter_supply    <= 1'b1;
      reference_level_select <= 2'b00;
      bandgap_enable         <= 1'b0;
      conv_done_irq          <= 1'b0;
    end else begin
      conv_clk_tick          <= tick;
      conv_busy              <= start_clear_control[`START_BIT];
      // First 26 converter clocks are sample and hold
      conv_sample            <= start_clear_control[`START_BIT] &
                                (conv_count < 6'd26);
      channel_sel            <= input_channel_select;
      chan_bandgap           <= (input_channel_select == 4'hb);
      chan_quarter_supply    <= (input_channel_select == 4'hf);
      reference_level_select <= reference_prescale_control[1:0];
      bandgap_enable         <= reference_prescale_control[`BANDGAP_EN_BIT];
      conv_done_irq          <= interrupt_flags[`DONE_BIT];
    end
  end

endmodule

// [sim/adc_seq_properties.sv]
// Port-level checker for the ADC sequencer
`timescale 1ns/1ns
module adc_seq_chk (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        conv_clk_tick,
  input wire        conv_busy,
  input wire        conv_sample,
  input wire [3:0]  channel_sel,
  input wire        chan_bandgap,
  input wire        chan_quarter_supply,
  input wire        conv_done_irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire       wr = psel && penable && pwrite;
  wire       st = wr && paddr == 12'h3e0;
  reg  [1:0] dsel;
  reg  [5:0] gap;
  reg  [5:0] nt;
  reg        seen;
  wire [5:0] dv = 6'd32 >> dsel;
  // Restart clears nt and seen so a restarted run is timed afresh
  always @(posedge pclk or negedge presetn)
    if (!presetn) begin
      dsel <= 2'd0;
      gap  <= 6'd0;
      nt   <= 6'd0;
      seen <= 1'b0;
    end else begin
      if (wr && paddr == 12'h250)
        dsel <= pwdata[3:2];
      gap  <= conv_clk_tick ? 6'd1 : gap + 6'd1;
      seen <= conv_busy && !st && (seen || conv_clk_tick);
      nt   <= st ? 6'd0 : nt + {5'd0, conv_busy && conv_clk_tick};
    end
  sequence s_go;   st && pwdata[4];  endsequence
  sequence s_stop; st && !pwdata[4]; endsequence
  sequence s_fclr; wr && paddr == 12'h254 && !pwdata[4]; endsequence
  property p_div;   conv_clk_tick && seen |-> gap == dv; endproperty
  property p_start; s_go |-> ##[1:2] conv_busy; endproperty
  property p_stop;  s_stop |-> ##[1:2] !conv_busy; endproperty
  property p_len;   $rose(conv_done_irq) |-> nt == 6'd50; endproperty
  property p_end;   $rose(conv_done_irq) |-> $fell(conv_busy); endproperty
  property p_clrgo; s_go |-> ##[1:2] !conv_done_irq; endproperty
  property p_clrwr; s_fclr |-> ##[1:2] !conv_done_irq; endproperty
  property p_samp;  conv_sample |-> conv_busy; endproperty
  property p_chan;
    chan_quarter_supply == (channel_sel == 4'hf) &&
    chan_bandgap == (channel_sel == 4'hb);
  endproperty
  a_div: assert property (p_div)
    else $error("converter tick spacing off");
  a_start: assert property (p_start)
    else $error("start did not begin conversion");
  a_stop: assert property (p_stop)
    else $error("zero write did not stop conversion");
  a_len: assert property (p_len)
    else $error("conversion length not 50 ticks");
  a_end: assert property (p_end)
    else $error("done and start clear not together");
  a_clrgo: assert property (p_clrgo)
    else $error("start did not clear done flag");
  a_clrwr: assert property (p_clrwr)
    else $error("flag write did not clear done flag");
  a_chan: assert property (p_chan)
    else $error("channel decode wrong");
  a_samp: assert property (p_samp)
    else $error("sampling outside a conversion");
endmodule
bind sar_adc_sequencer adc_seq_chk u_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .conv_clk_tick(conv_clk_tick), .conv_busy(conv_busy),
  .conv_sample(conv_sample),
  .channel_sel(channel_sel), .chan_bandgap(chan_bandgap),
  .chan_quarter_supply(chan_quarter_supply), .conv_done_irq(conv_done_irq));

// [sim/conv_core_model.sv]
// Behavioural converter core feeding the sequencer its result
`timescale 1ns/1ns
module conv_core_model (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        conv_busy,
  input  wire        conv_sample,
  input  wire [11:0] next_value,
  input  wire [3:0]  lat,
  output reg  [11:0] conv_data
);
  integer cnt;
  // Unsettled output toggles so a stale value is never mistaken for a result
  always @(posedge pclk or negedge presetn)
    if (!presetn) begin
      conv_data <= 12'h000;
      cnt       <= 0;
    end else if (conv_sample || !conv_busy) begin
      conv_data <= ~conv_data;
      cnt       <= 0;
    end else if (cnt < lat) begin
      conv_data <= ~conv_data;
      cnt       <= cnt + 1;
    end else
      conv_data <= next_value;
endmodule

// [sim/sar_adc_sequencer_tb.sv]
// Self-checking bench for the ADC sequencer
`timescale 1ns/1ns
module sar_adc_sequencer_tb;
  reg         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  reg  [11:0] paddr = 0, nv = 0;
  reg  [31:0] pwdata = 0;
  reg  [3:0]  lat = 0;
  reg  [7:0]  rd, v;
  reg         err;
  wire [31:0] prdata;
  wire [11:0] conv_data;
  wire [3:0]  channel_sel;
  wire [1:0]  reference_level_select;
  wire        pready, pslverr, conv_clk_tick, conv_busy, conv_sample;
  wire        chan_bandgap, chan_quarter_supply, bandgap_enable, conv_done_irq;
  integer     num_errors = 0, samples_checked = 0, seed = 31, i, n, r, dv;
  integer     res_q[$];
  sar_adc_sequencer dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .conv_data(conv_data), .conv_clk_tick(conv_clk_tick),
    .conv_busy(conv_busy), .conv_sample(conv_sample),
    .channel_sel(channel_sel), .chan_bandgap(chan_bandgap),
    .chan_quarter_supply(chan_quarter_supply),
    .reference_level_select(reference_level_select),
    .bandgap_enable(bandgap_enable), .conv_done_irq(conv_done_irq));
  conv_core_model core (.pclk(pclk), .presetn(presetn),
    .conv_busy(conv_busy), .conv_sample(conv_sample), .next_value(nv),
    .lat(lat), .conv_data(conv_data));
  task chk(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        num_errors = num_errors + 1;
        $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [7:0] d);
    begin
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
        @(posedge pclk);
        n = n + 1;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20)
        num_errors = num_errors + 1;
      rd = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task wr(input [7:0] idx, input [7:0] d);
    apb(1'b1, {2'b00, idx, 2'b00}, d);
  endtask
  task rc(input [7:0] idx, input [7:0] exp, input [7:0] m);
    begin
      apb(1'b0, {2'b00, idx, 2'b00}, 8'h00);
      chk(rd & m, exp);
    end
  endtask
  task test_done;
    begin
      $display("checks %0d, errors %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial forever #5 pclk = ~pclk;
  initial begin
    #400000;
    num_errors = num_errors + 1;
    test_done;
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rc(8'hf8, 8'h00, 8'hff);
    rc(8'h95, 8'h00, 8'h10);
    rc(8'hb6, 8'h0f, 8'h0f);
    apb(1'b0, 12'h000, 8'h00);
    chk({err, rd}, 9'h100);
    apb(1'b1, 12'h3e1, 8'h10);
    chk(err, 1'b1);
    rc(8'hf8, 8'h00, 8'hff);
    for (i = 0; i < 4; i = i + 1) begin
      v = $random(seed);
      v[1:0] = i;
      wr(8'hef, v);
      rc(8'hef, v & 8'h3f, 8'hff);
      chk({reference_level_select, bandgap_enable}, {v[1:0], v[2]});
    end
    wr(8'hef, 8'h00);
    chk(bandgap_enable, 1'b0);
    for (i = 0; i < 16; i = i + 1) begin
      wr(8'hb6, i);
      rc(8'hb6, i, 8'h0f);
      chk({chan_bandgap, chan_quarter_supply, channel_sel},
          {i == 11, i == 15, i[3:0]});
    end
    // Loop ends parked on quarter supply, off every shared pin
    chk(chan_quarter_supply, 1'b1);
    for (i = 0; i < 4; i = i + 1) begin
      // Fastest legal tick here exceeds 1 MHz: bench clock is fixed
      wr(8'h94, i << 2);
      rc(8'h94, i << 2, 8'h0c);
      r = $random(seed) & 12'hfff;
      nv <= r;
      lat <= $random(seed);
      res_q.push_back(r);
      wr(8'hf8, 8'h10);
      n = 0;
      while (conv_done_irq !== 1'b1 && n < 3000) begin
        @(posedge pclk);
        n = n + 1;
      end
      dv = 32 >> i;
      chk(n >= 50 * dv - 4 && n <= 50 * dv + dv + 8, 1'b1);
      r = res_q.pop_front();
      rc(8'hab, r >> 4, 8'hff);
      rc(8'haa, (r & 15) << 4, 8'hf0);
      rc(8'hf8, 8'h00, 8'h10);
      rc(8'h95, 8'h10, 8'h10);
      if (i % 2)
        wr(8'h95, 8'hef);
      else begin
        wr(8'hf8, 8'h10);
        wr(8'hf8, 8'h00);
      end
      rc(8'h95, 8'h00, 8'h10);
      rc(8'hf8, 8'h00, 8'h10);
    end
    test_done;
  end
endmodule
